// [hw/gpio_port.sv]
// Eight-pin GPIO port with APB registers, interrupts and pad control
//
// Function
// R1: Direction bit 0 makes the pin an input captured into the data register.
// R2: Direction bit 1 drives the data register bit onto the pin.
// R3: Data register spans 256 words; address bits [9:2] mask the pins.
// R4: Writes change only bits whose mask address bit is 1.
// R5: Reads return bits whose mask address bit is 1, zero elsewhere.
// R6: One combined port interrupt output for all enabled pin conditions.
// R7: Edge interrupts stay latched until software clears them.
// R8: Level sources hold their level until recognised; nothing is latched.
// R9: Sense, dual-edge and polarity settings jointly pick the trigger.
// R10: Rising, falling or both edges, or high or low level, per pin.
// R11: Mask bit gates each pin's condition onto the port interrupt.
// R12: Raw status ignores the mask; masked status shows allowed ones.
// R13: Writing 1 to the clear register clears a latch; 0 does nothing.
// R14: Software masks a pin while changing its trigger settings.
// R15: Unmasked converter trigger pin also pulses the converter trigger.
// R16: Alternate-function bit hands the pin to its peripheral.
// R17: Analog mode bit 1 removes the pin's analog isolation.
// R18: Protected writes need unlock and commit permission bit 1.
// R19: Drive, open-drain, pulls, slew and digital enable go to the pad.
// R20: Read-only identification words: eight peripheral, four cell.
// R21: Reset leaves pins undriven, debug pins keep their debug function.
// R22: Pin inputs pass a two-flop synchroniser before any use.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"
module gpio_port #(
   parameter logic [7:0] DEBUG_PIN_MASK = 8'h00,
   parameter logic [7:0] PROTECT_MASK = 8'h00,
   parameter logic [7:0] COMMIT_RESET = `GP_RST_COMMIT,
   parameter bit ADC_TRIG_EN = 1'b1,
   parameter int ADC_TRIG_PIN = 4,
   // Identification bytes are arbitrary values
   parameter logic [95:0] IDENT_BYTES = 96'h5a_a5_3c_c3_0f_f0_69_96_11_22_33_44
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   output logic [7:0] alt_in,
   output logic port_irq,
   output logic adc_trigger,
   output logic [7:0] drive_low_select,
   output logic [7:0] drive_mid_select,
   output logic [7:0] drive_high_select,
   output logic [7:0] open_drain_select,
   output logic [7:0] pull_up_select,
   output logic [7:0] pull_down_select,
   output logic [7:0] slew_rate_select,
   output logic [7:0] digital_input_enable,
   output logic [7:0] analog_mode_select,
   output logic [7:0] alt_function_select
);
   // ****************************************
   // Declarations
   // ****************************************
   gpio_port_pkg::apb_state_e state;
   gpio_port_pkg::pin_vec_t sync_pin, prev_pin;
   gpio_port_pkg::pin_vec_t pin_value_reg, pin_direction_reg;
   gpio_port_pkg::pin_vec_t trigger_sense_select, dual_edge_select;
   gpio_port_pkg::pin_vec_t trigger_polarity_select, irq_mask_reg;
   gpio_port_pkg::pin_vec_t raw_irq_status, masked_irq_status;
   gpio_port_pkg::pin_vec_t commit_permit_reg;
   gpio_port_pkg::pin_vec_t rise, fall, edge_hit, level_hit, clr_vec;
   gpio_port_pkg::pin_vec_t next_raw, data_wmask, commit_ok, rd_val;
   gpio_port_pkg::pin_vec_t base_out, base_oe, wbyte;
   logic locked, rd_err, wr_now;
   logic [3:0] id_idx;

   function automatic gpio_port_pkg::pin_vec_t addr_mask(
      input logic [11:0] a);
      return a[`GP_MASK_HI:`GP_MASK_LO];
   endfunction : addr_mask

   function automatic logic in_data(input logic [11:0] a);
      return a[11:10] == `GP_DATA_REGION;
   endfunction : in_data

   pin_sync #(.WIDTH(8)) u_sync ( // R22
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d(pin_in),
      .q(sync_pin)
   );

   // ****************************************
   // APB slave
   // ****************************************
   // One wait-free access phase; write lands at the completing edge
   assign wr_now = psel & penable & pready & pwrite & pstrb[0];
   assign wbyte = pwdata[7:0];
   assign id_idx = paddr[5:2] - `GP_ID_FIRST;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= gpio_port_pkg::APB_IDLE;
         pready <= 1'b0;
      end else begin
         case (state)
            gpio_port_pkg::APB_IDLE: begin
               if (psel && !penable) begin
                  state <= gpio_port_pkg::APB_ACCESS;
                  pready <= 1'b1;
               end
            end
            gpio_port_pkg::APB_ACCESS: begin
               state <= gpio_port_pkg::APB_IDLE;
               pready <= 1'b0;
            end
            default: begin
               state <= gpio_port_pkg::APB_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      rd_val = `GP_RST_ZERO;
      rd_err = 1'b0;
      if (in_data(paddr)) begin
         rd_val = pin_value_reg & addr_mask(paddr); // R5
      end else if (paddr[11:6] == `GP_ID_REGION &&
                   paddr[5:2] >= `GP_ID_FIRST) begin
         rd_val = IDENT_BYTES[id_idx*8 +: 8]; // R20
      end else begin
         case (paddr)
            `GP_OFF_DIR: rd_val = pin_direction_reg;
            `GP_OFF_SENSE: rd_val = trigger_sense_select;
            `GP_OFF_DUAL: rd_val = dual_edge_select;
            `GP_OFF_POL: rd_val = trigger_polarity_select;
            `GP_OFF_MASK: rd_val = irq_mask_reg;
            `GP_OFF_RAW: rd_val = raw_irq_status; // R12
            `GP_OFF_MIS: rd_val = masked_irq_status; // R12
            `GP_OFF_CLR: rd_val = `GP_RST_ZERO;
            `GP_OFF_AFSEL: rd_val = alt_function_select;
            `GP_OFF_DRV_LO: rd_val = drive_low_select;
            `GP_OFF_DRV_MID: rd_val = drive_mid_select;
            `GP_OFF_DRV_HI: rd_val = drive_high_select;
            `GP_OFF_OPEN_DR: rd_val = open_drain_select;
            `GP_OFF_PULL_UP: rd_val = pull_up_select;
            `GP_OFF_PULL_DN: rd_val = pull_down_select;
            `GP_OFF_SLEW: rd_val = slew_rate_select;
            `GP_OFF_DIG_EN: rd_val = digital_input_enable;
            `GP_OFF_LOCK: rd_val = {7'h00, locked};
            `GP_OFF_COMMIT: rd_val = commit_permit_reg;
            `GP_OFF_ANALOG: rd_val = analog_mode_select;
            default: rd_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= {`GP_BYTE_PAD, rd_val};
         pslverr <= rd_err;
      end else if (pready) begin
         pslverr <= 1'b0;
      end
   end

   // ****************************************
   // Data register and direction
   // ****************************************
   assign data_wmask = (wr_now && in_data(paddr)) ? addr_mask(paddr)
                                                  : `GP_RST_ZERO; // R3

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_value_reg <= `GP_RST_ZERO;
      end else begin
         pin_value_reg <= (~pin_direction_reg & sync_pin) | // R1
            (pin_direction_reg & ((pin_value_reg & ~data_wmask) |
                                  (wbyte & data_wmask))); // R4
      end
   end

   // ****************************************
   // Plain configuration registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_direction_reg <= `GP_RST_ZERO;
         trigger_sense_select <= `GP_RST_ZERO;
         dual_edge_select <= `GP_RST_ZERO;
         trigger_polarity_select <= `GP_RST_ZERO;
         irq_mask_reg <= `GP_RST_ZERO;
         open_drain_select <= `GP_RST_ZERO;
         pull_down_select <= `GP_RST_ZERO;
         slew_rate_select <= `GP_RST_ZERO;
         analog_mode_select <= `GP_RST_ZERO;
      end else if (wr_now) begin
         case (paddr)
            `GP_OFF_DIR: pin_direction_reg <= wbyte;
            `GP_OFF_SENSE: trigger_sense_select <= wbyte; // R9
            `GP_OFF_DUAL: dual_edge_select <= wbyte; // R9
            `GP_OFF_POL: trigger_polarity_select <= wbyte; // R9
            `GP_OFF_MASK: irq_mask_reg <= wbyte; // R11
            `GP_OFF_OPEN_DR: open_drain_select <= wbyte; // R19
            `GP_OFF_PULL_DN: pull_down_select <= wbyte; // R19
            `GP_OFF_SLEW: slew_rate_select <= wbyte; // R19
            `GP_OFF_ANALOG: analog_mode_select <= wbyte; // R17
            default: begin
            end
         endcase
      end
   end

   // Drive strengths are exclusive: selecting one clears the others
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_low_select <= `GP_RST_ZERO;
         drive_mid_select <= `GP_RST_ZERO;
         drive_high_select <= `GP_RST_ZERO;
      end else if (wr_now) begin
         case (paddr)
            `GP_OFF_DRV_LO: begin
               drive_low_select <= wbyte; // R19
               drive_mid_select <= drive_mid_select & ~wbyte;
               drive_high_select <= drive_high_select & ~wbyte;
            end
            `GP_OFF_DRV_MID: begin
               drive_mid_select <= wbyte; // R19
               drive_low_select <= drive_low_select & ~wbyte;
               drive_high_select <= drive_high_select & ~wbyte;
            end
            `GP_OFF_DRV_HI: begin
               drive_high_select <= wbyte; // R19
               drive_low_select <= drive_low_select & ~wbyte;
               drive_mid_select <= drive_mid_select & ~wbyte;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Lock and commit protection
   // ****************************************
   // Unprotected bits need only their commit bit; protected ones also need the unlock
   assign commit_ok = commit_permit_reg &
                      (~PROTECT_MASK | {8{~locked}}); // R18

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         locked <= 1'b1;
         commit_permit_reg <= COMMIT_RESET;
      end else if (wr_now) begin
         if (paddr == `GP_OFF_LOCK) begin
            locked <= (pwdata != `GP_LOCK_KEY);
         end
         if (paddr == `GP_OFF_COMMIT && !locked) begin
            commit_permit_reg <= wbyte; // R18
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_function_select <= DEBUG_PIN_MASK; // R21
         pull_up_select <= DEBUG_PIN_MASK; // R21
         digital_input_enable <= DEBUG_PIN_MASK; // R21
      end else if (wr_now) begin
         case (paddr)
            `GP_OFF_AFSEL: alt_function_select <= // R18
               (alt_function_select & ~commit_ok) | (wbyte & commit_ok);
            `GP_OFF_PULL_UP: pull_up_select <= // R18
               (pull_up_select & ~commit_ok) | (wbyte & commit_ok);
            `GP_OFF_DIG_EN: digital_input_enable <= // R18
               (digital_input_enable & ~commit_ok) | (wbyte & commit_ok);
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Interrupt detection
   // ****************************************
   always_comb begin
      rise = sync_pin & ~prev_pin;
      fall = ~sync_pin & prev_pin;
      edge_hit = (dual_edge_select & (rise | fall)) | // R10
         (~dual_edge_select & trigger_polarity_select & rise) |
         (~dual_edge_select & ~trigger_polarity_select & fall);
      level_hit = (trigger_polarity_select & sync_pin) | // R10
         (~trigger_polarity_select & ~sync_pin);
      clr_vec = (wr_now && paddr == `GP_OFF_CLR) ? wbyte
                                                 : `GP_RST_ZERO; // R13
      // New edge beats a clear in the same cycle; level is never held
      next_raw = (trigger_sense_select & level_hit) | // R8
         (~trigger_sense_select &
          ((raw_irq_status & ~clr_vec) | edge_hit)); // R7
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_pin <= `GP_RST_ZERO;
         raw_irq_status <= `GP_RST_ZERO;
         masked_irq_status <= `GP_RST_ZERO;
         port_irq <= 1'b0;
      end else begin
         prev_pin <= sync_pin;
         raw_irq_status <= next_raw; // R12
         masked_irq_status <= next_raw & irq_mask_reg; // R11
         port_irq <= |(next_raw & irq_mask_reg); // R6
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_trigger <= 1'b0;
      end else begin
         adc_trigger <= ADC_TRIG_EN & irq_mask_reg[ADC_TRIG_PIN] & // R15
            next_raw[ADC_TRIG_PIN] & ~raw_irq_status[ADC_TRIG_PIN];
      end
   end

   // ****************************************
   // Pad drive
   // ****************************************
   assign base_out = (alt_function_select & alt_out) |
                     (~alt_function_select & pin_value_reg); // R16
   assign base_oe = (alt_function_select & alt_oe) |
                    (~alt_function_select & pin_direction_reg); // R2

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= `GP_RST_ZERO;
         pin_oe <= `GP_RST_ZERO; // R21
         alt_in <= `GP_RST_ZERO;
      end else begin
         // Open drain only ever pulls low
         pin_out <= base_out & ~open_drain_select; // R2
         pin_oe <= base_oe & ~(open_drain_select & base_out); // R19
         alt_in <= sync_pin; // R16
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_data_wr;
      psel && penable && pready && pwrite && pstrb[0] && in_data(paddr);
   endsequence

   property p_input_capture;
      1 |=> ((pin_value_reg ^ $past(sync_pin)) &
             ~$past(pin_direction_reg)) == 8'h00;
   endproperty
   a_input_capture: assert property (p_input_capture) // R1
      else $error("input pin not captured");

   property p_output_drive;
      1 |=> ((pin_out ^ $past(pin_value_reg)) & $past(pin_direction_reg &
             ~alt_function_select & ~open_drain_select)) == 8'h00;
   endproperty
   a_output_drive: assert property (p_output_drive) // R2
      else $error("output pin not driven from data");

   property p_masked_write;
      s_data_wr |=> ((pin_value_reg ^ $past(pin_value_reg)) &
         $past(pin_direction_reg & ~addr_mask(paddr))) == 8'h00;
   endproperty
   a_masked_write: assert property (p_masked_write) // R4
      else $error("unmasked data bit changed");

   property p_masked_read;
      s_setup ##1 (!pwrite && in_data(paddr) && pready) |->
         prdata == {24'h000000, $past(pin_value_reg) & addr_mask(paddr)};
   endproperty
   a_masked_read: assert property (p_masked_read) // R5
      else $error("masked read value wrong");

   property p_port_irq;
      port_irq == (masked_irq_status != 8'h00);
   endproperty
   a_port_irq: assert property (p_port_irq) // R6
      else $error("port interrupt disagrees with masked status");

   property p_mis_gate;
      1 |=> masked_irq_status == (raw_irq_status & $past(irq_mask_reg));
   endproperty
   a_mis_gate: assert property (p_mis_gate) // R12
      else $error("masked status not raw and mask");

   property p_edge_hold;
      1 |=> ($past(raw_irq_status & ~trigger_sense_select & ~clr_vec) &
             ~raw_irq_status) == 8'h00;
   endproperty
   a_edge_hold: assert property (p_edge_hold) // R7
      else $error("edge latch dropped without clear");

   property p_clear;
      1 |=> ($past(clr_vec & ~trigger_sense_select & ~edge_hit) &
             raw_irq_status) == 8'h00;
   endproperty
   a_clear: assert property (p_clear) // R13
      else $error("clear did not clear latch");

   property p_level;
      1 |=> ((raw_irq_status ^ $past(level_hit)) &
             $past(trigger_sense_select)) == 8'h00;
   endproperty
   a_level: assert property (p_level) // R10
      else $error("level status does not follow pin");

   property p_adc_trig;
      adc_trigger |-> $past(irq_mask_reg[ADC_TRIG_PIN]) &&
         raw_irq_status[ADC_TRIG_PIN] && port_irq;
   endproperty
   a_adc_trig: assert property (p_adc_trig) // R15
      else $error("converter trigger without unmasked event");

   property p_locked_afsel;
      wr_now && paddr == `GP_OFF_AFSEL && locked |=>
         ((alt_function_select ^ $past(alt_function_select)) &
          PROTECT_MASK) == 8'h00;
   endproperty
   a_locked_afsel: assert property (p_locked_afsel) // R18
      else $error("protected bit written while locked");
endmodule : gpio_port

// [hw/gpio_port_defines.svh]
// Register offsets, reset values and field positions of the GPIO port
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

`define GP_OFF_DIR 12'h400
`define GP_OFF_SENSE 12'h404
`define GP_OFF_DUAL 12'h408
`define GP_OFF_POL 12'h40c
`define GP_OFF_MASK 12'h410
`define GP_OFF_RAW 12'h414
`define GP_OFF_MIS 12'h418
`define GP_OFF_CLR 12'h41c
`define GP_OFF_AFSEL 12'h420
`define GP_OFF_DRV_LO 12'h500
`define GP_OFF_DRV_MID 12'h504
`define GP_OFF_DRV_HI 12'h508
`define GP_OFF_OPEN_DR 12'h50c
`define GP_OFF_PULL_UP 12'h510
`define GP_OFF_PULL_DN 12'h514
`define GP_OFF_SLEW 12'h518
`define GP_OFF_DIG_EN 12'h51c
`define GP_OFF_LOCK 12'h520
`define GP_OFF_COMMIT 12'h524
`define GP_OFF_ANALOG 12'h528

// Data window: address bits [11:10] zero, mask in bits [9:2]
`define GP_DATA_REGION 2'b00
`define GP_MASK_HI 9
`define GP_MASK_LO 2
// Identification words at 0xfd0..0xffc, twelve bytes
`define GP_ID_REGION 6'h3f
`define GP_ID_FIRST 4'h4
`define GP_ID_LAST 4'hf

`define GP_RST_ZERO 8'h00
`define GP_RST_COMMIT 8'hff
// Unlock key value is arbitrary
`define GP_LOCK_KEY 32'h6c0c_a11e
`define GP_BYTE_PAD 24'h000000

`endif

// [hw/gpio_port_pkg.sv]
// Types shared by the GPIO port design
package gpio_port_pkg;
   typedef logic [7:0] pin_vec_t;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ACCESS = 2'b10
   } apb_state_e;
endpackage : gpio_port_pkg

// [hw/pin_sync.sv]
// Two-flop synchroniser for the pad inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : pin_sync

// [tb/pad_partner.sv]
// Pad-side partner: package pins and alternate-function peripheral
`timescale 1ns/1ps
module pad_partner (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   input wire logic [7:0] periph_val,
   input wire logic [7:0] periph_oe,
   output logic [7:0] pin_in,
   output logic [7:0] alt_out,
   output logic [7:0] alt_oe
);
   // Undriven pins follow the outside world, driven ones the port
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
   assign alt_out = periph_val;
   assign alt_oe = periph_oe;
endmodule : pad_partner

// [tb/tb_top.sv]
// Self-checking bench for the eight-pin GPIO port
`timescale 1ns/1ps
`include "gpio_port_defines.svh"
module tb_top;
   // Arbitrary identification bytes
   localparam logic [95:0] ID_BYTES = 96'h0123456789abcdef5aa5c33c;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, port_irq, adc_trigger;
   logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
   logic [7:0] drive_low_select, drive_mid_select, drive_high_select;
   logic [7:0] open_drain_select, pull_up_select, pull_down_select;
   logic [7:0] slew_rate_select, digital_input_enable;
   logic [7:0] analog_mode_select, alt_function_select;
   logic [7:0] ext = 8'h00;
   logic [7:0] pval = 8'h00;
   logic [7:0] poe = 8'h00;
   logic [7:0] model;
   logic [7:0] pad_seen [6];
   logic [11:0] pad_off [6] = '{12'h50c, 12'h510, 12'h514, 12'h518,
      12'h51c, 12'h528};
   // Sense, dual edge, polarity, idle level
   logic [3:0] modes [5] = '{4'b0010, 4'b0001, 4'b0100, 4'b1010, 4'b1001};
   logic [3:0] md;
   logic [32:0] exp_q [$];
   logic [32:0] note;
   logic [31:0] trig_count = 32'h0;
   logic [31:0] tc, lat;
   logic [15:0] rnd = 16'h07cc;
   int failures = 0;
   int total_checks = 0;

   gpio_port #(.DEBUG_PIN_MASK(8'h0f), .PROTECT_MASK(8'h0f),
      .COMMIT_RESET(8'hf0), .IDENT_BYTES(ID_BYTES)) i_gpio_port (
      .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .pin_in, .pin_out,
      .pin_oe, .alt_out, .alt_oe, .alt_in, .port_irq, .adc_trigger,
      .drive_low_select, .drive_mid_select, .drive_high_select,
      .open_drain_select, .pull_up_select, .pull_down_select,
      .slew_rate_select, .digital_input_enable, .analog_mode_select,
      .alt_function_select);
   pad_partner i_pad_partner (.pin_out, .pin_oe, .ext_level(ext),
      .periph_val(pval), .periph_oe(poe), .pin_in, .alt_out, .alt_oe);
   assign pad_seen = '{open_drain_select, pull_up_select,
      pull_down_select, slew_rate_select, digital_input_enable,
      analog_mode_select};

   // ****************************************
   // Bus tasks, checking and run control
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic check_val(input string nm, input logic [31:0] e,
         input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : check_val

   task automatic xfer(input logic [11:0] a, input logic w,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge keeps two requests from landing in one time step
      @(posedge core_clk);
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
         input logic err = 1'b0);
      exp_q.push_back({err, e});
      xfer(a, 1'b0, 32'h0);
   endtask : rd

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         note = exp_q.pop_front();
         check_val("prdata", note[31:0], prdata);
         check_val("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      end
      if (adc_trigger === 1'b1) begin
         trig_count <= trig_count + 32'h1;
      end
   end

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      #100000;
      failures++;
      complete_run();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      check_val("afsel", 8'h0f, alt_function_select);
      check_val("pull_up", 8'h0f, pull_up_select);
      check_val("dig_en", 8'h0f, digital_input_enable);
      check_val("pin_oe", 8'h00, pin_oe);
      rd(`GP_OFF_LOCK, 32'h1);
      wr(`GP_OFF_AFSEL, 32'h0);
      wr(`GP_OFF_COMMIT, 32'hff);
      rd(`GP_OFF_AFSEL, 32'h0f);
      rd(`GP_OFF_COMMIT, 32'hf0);
      wr(`GP_OFF_LOCK, `GP_LOCK_KEY);
      rd(`GP_OFF_LOCK, 32'h0);
      wr(`GP_OFF_AFSEL, 32'h0);
      rd(`GP_OFF_AFSEL, 32'h0f);
      wr(`GP_OFF_COMMIT, 32'hff);
      wr(`GP_OFF_AFSEL, 32'hf0);
      rd(`GP_OFF_AFSEL, 32'hf0);
      rnd = lfsr(rnd);
      pval <= rnd[7:0];
      poe <= rnd[15:8];
      repeat (3) @(posedge core_clk);
      check_val("alt_out", pval & 8'hf0, pin_out & 8'hf0);
      check_val("alt_oe", poe & 8'hf0, pin_oe & 8'hf0);
      wr(`GP_OFF_AFSEL, 32'h0);
      wr(`GP_OFF_DIR, 32'hff);
      wr(12'h3fc, 32'h0);
      model = 8'h00;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr({2'b00, rnd[7:0], 2'b00}, {24'h0, rnd[15:8]});
         model = (model & ~rnd[7:0]) | (rnd[15:8] & rnd[7:0]);
         rd({2'b00, rnd[15:8], 2'b00}, {24'h0, model & rnd[15:8]});
         check_val("pin_out", model, pin_out);
      end
      check_val("pin_oe", 8'hff, pin_oe);
      wr(`GP_OFF_DIR, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         ext <= rnd[7:0];
         repeat (4) @(posedge core_clk);
         rd({2'b00, rnd[15:8], 2'b00}, {24'h0, rnd[7:0] & rnd[15:8]});
         check_val("alt_in", rnd[7:0], alt_in);
      end
      foreach (modes[k]) begin
         md = modes[k];
         wr(`GP_OFF_MASK, 32'h0);
         ext[4] <= md[0];
         repeat (5) @(posedge core_clk);
         wr(`GP_OFF_SENSE, {27'h0, md[3], 4'h0});
         wr(`GP_OFF_DUAL, {27'h0, md[2], 4'h0});
         wr(`GP_OFF_POL, {27'h0, md[1], 4'h0});
         // Earlier pin traffic can leave edges latched on pin 4 or other pins; clear all eight
         wr(`GP_OFF_CLR, 32'hff);
         wr(`GP_OFF_MASK, 32'h10);
         rd(`GP_OFF_RAW, 32'h0);
         tc = trig_count;
         // Pin 4 moves to its trigger level or edge and holds it until recognised
         ext[4] <= ~md[0];
         repeat (5) @(posedge core_clk);
         rd(`GP_OFF_RAW, 32'h10);
         rd(`GP_OFF_MIS, 32'h10);
         check_val("port_irq", 32'h1, port_irq);
         check_val("adc_trig", tc + 32'h1, trig_count);
         ext[4] <= md[0];
         repeat (5) @(posedge core_clk);
         lat = md[3] ? 32'h0 : 32'h10;
         rd(`GP_OFF_RAW, lat);
         wr(`GP_OFF_CLR, 32'h0);
         rd(`GP_OFF_RAW, lat);
         wr(`GP_OFF_CLR, 32'h10);
         rd(`GP_OFF_RAW, 32'h0);
         wr(`GP_OFF_MASK, 32'h0);
         ext[4] <= ~md[0];
         repeat (5) @(posedge core_clk);
         rd(`GP_OFF_RAW, 32'h10);
         rd(`GP_OFF_MIS, 32'h0);
         check_val("irq_masked", 32'h0, port_irq);
      end
      foreach (pad_off[i]) begin
         rnd = lfsr(rnd);
         wr(pad_off[i], {24'h0, rnd[7:0]});
         rd(pad_off[i], {24'h0, rnd[7:0]});
         check_val("pad", rnd[7:0], pad_seen[i]);
      end
      wr(`GP_OFF_DRV_LO, 32'hff);
      wr(`GP_OFF_DRV_MID, 32'h3c);
      wr(`GP_OFF_DRV_HI, 32'h0f);
      check_val("drv_lo", 8'hc0, drive_low_select);
      check_val("drv_mid", 8'h30, drive_mid_select);
      check_val("drv_hi", 8'h0f, drive_high_select);
      for (int i = 0; i < 12; i++) begin
         wr(12'hfd0 + 12'(4 * i), 32'hff);
         rd(12'hfd0 + 12'(4 * i), {24'h0, ID_BYTES[i * 8 +: 8]});
      end
      rd(12'h600, 32'h0, 1'b1);
      complete_run();
   end
endmodule : tb_top
